// ---- src/pfadc_port.sv ----
// Digital port of the supply-feedback converter: sampling strobe, arm
// detection, code buffering, serialisation with frame sync, overrange flag.
// Assumes the analog modulator delivers a code and an overrange level
// synchronous to mclk_i; all inputs except arst_n_i are synchronous to mclk_i.
`timescale 1ns/1ps
module pfadc_port (
  input  wire logic                       mclk_i,            // Master clock, sole timing source
  input  wire logic                       arst_n_i,          // Converter reset, active low
  input  wire logic                       feedback_arm_in_i, // Arm input, falling edge arms
  input  wire logic [pfadc_pkg::WORD_W-1:0] mod_code_i,      // Modulator code for this sample
  input  wire logic                       mod_ovr_i,         // Modulator overrange level
  output logic                            sample_stb_o,      // One-cycle sampling strobe
  output logic                            low_power_o,       // High while in reset power-down
  output logic                            frame_sync_out_o,  // Frame sync to PWM modulator
  output logic                            serial_code_out_o, // Serial code stream
  output logic                            data_valid_o,      // High once settling has ended
  output logic                            overflow_n_o,      // Open-drain flag output level
  output logic                            overflow_oe_o      // High while pulling flag low
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_r, rst_n;   // Two-flop reset release
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Power-down follows the held reset; the clock can then stop too
  assign low_power_o = !rst_n;

  // ----------------------------------------------------------------
  // Sample divider and settling counter
  // ----------------------------------------------------------------
  logic [1:0]  div_r, div_nxt;          // Master clocks within a sample
  logic [31:0] settle_r, settle_nxt;    // Cycles left before data is valid
  logic        settled;
  logic        stb;

  always_comb begin
    div_nxt    = div_r + 2'h1;
    stb        = (div_r == 2'(pfadc_pkg::SAMPLE_DIV - 1));
    settle_nxt = (settle_r != 32'h0) ? settle_r - 32'h1 : settle_r;
    settled    = (settle_r == 32'h0);
  end

  // Divider and settling count register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_r    <= pfadc_pkg::DIV_RST;
      settle_r <= 32'(pfadc_pkg::SETTLE_CYC);
    end else begin
      div_r    <= div_nxt;
      settle_r <= settle_nxt;
    end
  end

  assign sample_stb_o = stb;
  assign data_valid_o = settled;

  // ----------------------------------------------------------------
  // Arm detection: a falling edge on the arm input enables the path
  // ----------------------------------------------------------------
  logic arm_d_r, arm_d_nxt;   // Previous arm level
  logic armed_r, armed_nxt;   // Feedback path enabled

  always_comb begin
    arm_d_nxt = feedback_arm_in_i;
    armed_nxt = armed_r || (arm_d_r && !feedback_arm_in_i);
  end

  // Arm state; previous level starts low so a pin held low through reset gives no false edge
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      arm_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      arm_d_r <= arm_d_nxt;
      armed_r <= armed_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Code buffer: written once per sample, drained by the serialiser
  // ----------------------------------------------------------------
  logic                          run;       // Streaming allowed
  logic                          f_wready;
  logic [pfadc_pkg::WORD_W-1:0]  f_rdata;
  logic                          f_rvalid;
  logic                          f_rready;

  // Codes taken before settling would be garbage, so nothing enters until then
  assign run = armed_r && settled;

  pfadc_fifo #(
    .W (pfadc_pkg::WORD_W),
    .D (pfadc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i    (mclk_i),
    .rst_n_i  (rst_n),
    .clr_i    (!run),
    .wdata_i  (mod_code_i),
    .wvalid_i (run && stb),
    .wready_o (f_wready),
    .rdata_o  (f_rdata),
    .rvalid_o (f_rvalid),
    .rready_i (f_rready)
  );

  // ----------------------------------------------------------------
  // Serialiser: one bit per master clock, WORD_W bits per word
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {PFADC_IDLE, PFADC_SHIFT} pfadc_ser_t;
  pfadc_ser_t                    st_r, st_nxt;
  logic [pfadc_pkg::WORD_W-1:0]  sh_r, sh_nxt;     // Word being sent
  logic [1:0]                    bit_r, bit_nxt;   // Bit slot in word
  logic                          dat_r, dat_nxt;   // Registered data line
  logic                          syn_r, syn_nxt;   // Registered sync line
  logic                          ovf_r, ovf_nxt;   // Pull flag

  always_comb begin
    st_nxt   = st_r;
    sh_nxt   = sh_r;
    bit_nxt  = bit_r;
    dat_nxt  = pfadc_pkg::IDLE_DATA;
    syn_nxt  = pfadc_pkg::IDLE_SYNC;
    f_rready = 1'b0;
    ovf_nxt  = mod_ovr_i;
    case (st_r)
      PFADC_IDLE: begin
        if (run && f_rvalid) begin
          f_rready = 1'b1;
          sh_nxt   = f_rdata;
          bit_nxt  = pfadc_pkg::BIT_RST;
          st_nxt   = PFADC_SHIFT;
        end
      end
      PFADC_SHIFT: begin
        // bit order selected by package constant
        dat_nxt = pfadc_pkg::MSB_FIRST ? sh_r[pfadc_pkg::WORD_W-1 - 32'(bit_r)] : sh_r[bit_r];
        syn_nxt = (bit_r == 2'(pfadc_pkg::SYNC_POS));
        if (!run) begin
          st_nxt = PFADC_IDLE;
        end else if (bit_r == 2'(pfadc_pkg::WORD_W - 1)) begin
          // Next word back to back when available, keeps the line gapless
          f_rready = f_rvalid;
          sh_nxt   = f_rdata;
          bit_nxt  = pfadc_pkg::BIT_RST;
          st_nxt   = f_rvalid ? PFADC_SHIFT : PFADC_IDLE;
        end else begin
          bit_nxt = bit_r + 2'h1;
        end
      end
      default: begin
        st_nxt = PFADC_IDLE;
      end
    endcase
  end

  // Serialiser and flag registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= PFADC_IDLE;
      sh_r  <= '0;
      bit_r <= pfadc_pkg::BIT_RST;
      dat_r <= pfadc_pkg::IDLE_DATA;
      syn_r <= pfadc_pkg::IDLE_SYNC;
      ovf_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      sh_r  <= sh_nxt;
      bit_r <= bit_nxt;
      dat_r <= dat_nxt;
      syn_r <= syn_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Outputs from flip-flops; open-drain pin only ever drives low
  assign serial_code_out_o = dat_r;
  assign frame_sync_out_o  = syn_r;
  assign overflow_n_o      = 1'b0;
  assign overflow_oe_o     = ovf_r;
  // f_wready unused: 1 word per 4 clocks vs 4 bits at 1 per clock never overfills
  logic unused_ok;
  assign unused_ok = f_wready;

endmodule : pfadc_port

// ---- src/pfadc_pkg.sv ----
// Shared constants of the supply-feedback converter digital port.
// Assumes a single 20 MHz master clock and no software-visible registers.
// Function
// - Reset low holds all state, low power
// - Master clock times modulator and output
// - One sample every four master clocks
// - Drive frame sync for receiver alignment
// - Drive serial code stream to modulator
// - Falling edge of arm input enables path
// - Overrange pulls open-drain flag low one clock later
// - Flag held low while overrange persists
// - Data invalid during settling after reset
// - Reset low with static inputs is power-down
package pfadc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000; // Master clock rate
  localparam int unsigned SAMPLE_DIV     = 4;          // Master clocks per sample
  localparam int unsigned SETTLE_US      = 100;        // Settling time after reset
  localparam int unsigned SETTLE_CYC     = (SETTLE_US * (CLK_HZ / 1_000_000)); // Exact here; the MHz division truncates

  // ----------------------------------------------------------------
  // Serial word format
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W         = 4;          // Bits per modulator code
  localparam bit          MSB_FIRST      = 1'b1;       // Bit order on the line
  localparam int unsigned SYNC_POS       = 0;          // Bit slot carrying the sync pulse
  localparam int unsigned FIFO_DEPTH     = 8;          // Code words buffered

  // ----------------------------------------------------------------
  // Idle and reset levels
  // ----------------------------------------------------------------
  localparam logic        IDLE_DATA      = 1'b0;       // Data line when not streaming
  localparam logic        IDLE_SYNC      = 1'b0;       // Sync line when not streaming
  localparam logic [1:0]  DIV_RST        = 2'h0;       // Sample divider reset
  localparam logic [1:0]  BIT_RST        = 2'h0;       // Bit counter reset

endpackage : pfadc_pkg

// ---- src/pfadc_fifo.sv ----
// Synchronous FIFO for modulator code words.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/1ps
module pfadc_fifo #(
  parameter int unsigned W = 4, // Word width
  parameter int unsigned D = 8  // Depth, power of two
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clr_i,     // Synchronous flush
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         wvalid_i,
  output logic              wready_o,
  output logic [W-1:0]      rdata_o,
  output logic              rvalid_o,
  input  wire logic         rready_i
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_r [D];     // Storage array
  logic [AW:0]  wp_r, wp_nxt;  // Write pointer with wrap bit
  logic [AW:0]  rp_r, rp_nxt;  // Read pointer with wrap bit
  logic         wr, rd;

  // ----------------------------------------------------------------
  // Flags and pointer steps
  // ----------------------------------------------------------------
  always_comb begin
    wready_o = (wp_r - rp_r) != (AW+1)'(D); // Honest full
    rvalid_o = wp_r != rp_r;                // Honest empty
    rdata_o  = mem_r[rp_r[AW-1:0]];
    wr       = wvalid_i && wready_o;
    rd       = rvalid_o && rready_i;
    wp_nxt   = clr_i ? '0 : wp_r + (AW+1)'(wr);
    rp_nxt   = clr_i ? '0 : rp_r + (AW+1)'(rd);
  end

  // Pointers register only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage has no reset to keep it plain RAM
  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem_r[wp_r[AW-1:0]] <= wdata_i;
    end
  end
endmodule : pfadc_fifo

// ---- tb/pfadc_port_properties.sv ----
// Concurrent checks on the converter port outputs.
// Assumes a bind onto pfadc_port; sees only its ports.
`timescale 1ns/1ps
module pfadc_port_properties (
  input wire logic                           mclk_i,
  input wire logic                           arst_n_i,
  input wire logic                           feedback_arm_in_i,
  input wire logic [pfadc_pkg::WORD_W-1:0]   mod_code_i,
  input wire logic                           mod_ovr_i,
  input wire logic                           sample_stb_o,
  input wire logic                           low_power_o,
  input wire logic                           frame_sync_out_o,
  input wire logic                           serial_code_out_o,
  input wire logic                           data_valid_o,
  input wire logic                           overflow_n_o,
  input wire logic                           overflow_oe_o
);
  // Cycles since reset release; saturates so it never wraps
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  always_comb begin
    cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h1;
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_r <= 16'h0;
    else cnt_r <= cnt_nxt;
  end
  // First edge is skipped: the design's flops have seen no clock before it
  logic started_r = 1'b0;
  always_ff @(posedge mclk_i) started_r <= 1'b1;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Reset check must not be disabled by the reset it watches
  a_reset_quiet: assert property (disable iff (1'b0) started_r && !arst_n_i |-> low_power_o && !frame_sync_out_o
    && !data_valid_o && !overflow_oe_o) else $error("outputs active in reset");
  a_strobe_period: assert property (sample_stb_o |=> !sample_stb_o [*3] ##1 sample_stb_o)
    else $error("strobe period wrong");
  a_sync_spacing: assert property (frame_sync_out_o |=> !frame_sync_out_o [*3])
    else $error("sync spacing wrong");
  a_idle_settle: assert property (!data_valid_o |-> !frame_sync_out_o && serial_code_out_o == pfadc_pkg::IDLE_DATA)
    else $error("stream not idle while settling");
  a_valid_hold: assert property (data_valid_o |=> data_valid_o)
    else $error("valid dropped");
  a_settle_count: assert property ($rose(data_valid_o) |-> cnt_r >= pfadc_pkg::SETTLE_CYC
    && cnt_r <= pfadc_pkg::SETTLE_CYC + 6) else $error("settling length wrong");
  a_ovr_follow: assert property (!low_power_o [*2] ##0 mod_ovr_i |=> overflow_oe_o)
    else $error("flag not pulled");
  a_ovr_clear: assert property (!low_power_o [*2] ##0 !mod_ovr_i |=> !overflow_oe_o)
    else $error("flag not released");
  a_flag_drive: assert property (overflow_oe_o |-> overflow_n_o == 1'b0)
    else $error("flag driven high");
  c_word: cover property (frame_sync_out_o && serial_code_out_o);
  c_ovr: cover property ($rose(overflow_oe_o));
  c_valid: cover property ($rose(data_valid_o));
endmodule : pfadc_port_properties
bind pfadc_port pfadc_port_properties pfadc_port_properties_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .feedback_arm_in_i(feedback_arm_in_i), .mod_code_i(mod_code_i), .mod_ovr_i(mod_ovr_i),
  .sample_stb_o(sample_stb_o), .low_power_o(low_power_o), .frame_sync_out_o(frame_sync_out_o),
  .serial_code_out_o(serial_code_out_o), .data_valid_o(data_valid_o), .overflow_n_o(overflow_n_o),
  .overflow_oe_o(overflow_oe_o));

// ---- tb/pfadc_pwm_rx.sv ----
// Behavioural receiver of the PWM modulator side: frames on sync.
// Assumes sync marks the first, most significant bit of each word.
`timescale 1ns/1ps
module pfadc_pwm_rx (
  input  wire logic                          clk_i,
  input  wire logic                          sync_i,
  input  wire logic                          data_i,
  output logic [pfadc_pkg::WORD_W-1:0]       word_o,
  output logic                               word_stb_o
);
  logic [pfadc_pkg::WORD_W-1:0] sh_r = '0; // Bits gathered so far
  int                           cnt_r = 0;  // Bits taken of this word
  initial word_stb_o = 1'b0;
  // Sampled on the master clock only; bits outside a frame are ignored
  always @(posedge clk_i) begin
    word_stb_o <= 1'b0;
    if (sync_i === 1'b1) begin
      sh_r <= pfadc_pkg::WORD_W'(data_i);
      cnt_r <= 1;
    end else if (cnt_r > 0) begin
      sh_r <= {sh_r[pfadc_pkg::WORD_W-2:0], data_i};
      cnt_r <= cnt_r + 1;
      if (cnt_r == pfadc_pkg::WORD_W - 1) begin
        word_o <= {sh_r[pfadc_pkg::WORD_W-2:0], data_i};
        word_stb_o <= 1'b1;
        cnt_r <= 0;
      end
    end
  end
endmodule : pfadc_pwm_rx

// ---- tb/pfadc_port_tb.sv ----
// Self-checking bench of the converter port with a receiver model.
// Assumes the design and receiver files are compiled first.
`timescale 1ns/1ps
module pfadc_port_tb;
  logic                           mclk_i = 1'b0;
  logic                           arst_n_i, feedback_arm_in_i, mod_ovr_i;
  logic [pfadc_pkg::WORD_W-1:0]   mod_code_i, rx_word;
  logic                           sample_stb_o, low_power_o, frame_sync_out_o, serial_code_out_o;
  logic                           data_valid_o, overflow_n_o, overflow_oe_o, rx_stb;
  int                             errors = 0, n_compared = 0, n_words = 0;
  bit                             armed_exp = 1'b0; // Codes are expected only once armed
  logic [pfadc_pkg::WORD_W-1:0]   exp_q[$];
  pfadc_port pfadc_port_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .feedback_arm_in_i(feedback_arm_in_i),
    .mod_code_i(mod_code_i), .mod_ovr_i(mod_ovr_i), .sample_stb_o(sample_stb_o), .low_power_o(low_power_o),
    .frame_sync_out_o(frame_sync_out_o), .serial_code_out_o(serial_code_out_o), .data_valid_o(data_valid_o),
    .overflow_n_o(overflow_n_o), .overflow_oe_o(overflow_oe_o));
  pfadc_pwm_rx pfadc_pwm_rx_inst (.clk_i(mclk_i), .sync_i(frame_sync_out_o), .data_i(serial_code_out_o),
    .word_o(rx_word), .word_stb_o(rx_stb));
  initial forever #25 mclk_i = ~mclk_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Random codes and overrange; a code is noted when it will be taken.
  // Forked from the seeded thread so that the seed reaches these values.
  task automatic drive_loop;
    logic [pfadc_pkg::WORD_W-1:0] c;
    mod_code_i <= '0;
    mod_ovr_i <= 1'b0;
    forever begin
      @(negedge mclk_i);
      c = pfadc_pkg::WORD_W'($urandom);
      mod_code_i <= c;
      mod_ovr_i <= ($urandom_range(7) == 0);
      if (sample_stb_o === 1'b1 && data_valid_o === 1'b1 && armed_exp) exp_q.push_back(c);
    end
  endtask : drive_loop
  // Low power level seen at the previous falling edge
  logic lp_prev = 1'b1;
  // Each received word is matched against the oldest note; flag checked every cycle out of reset
  always @(negedge mclk_i) begin
    if (rx_stb === 1'b1) begin
      n_words++;
      if (exp_q.size() == 0) check("spare word", 32'h1, 32'h0);
      else check("word", 32'(rx_word), 32'(exp_q.pop_front()));
    end
    // Flag follows the level taken at the last rising edge, once out of reset
    if (low_power_o === 1'b0 && lp_prev === 1'b0) begin
      check("flag pull", 32'(overflow_oe_o), 32'(mod_ovr_i));
      check("flag level", 32'(overflow_n_o), 32'h0);
    end
    lp_prev = low_power_o;
  end
  initial begin
    void'($urandom(32'h8051));
    arst_n_i = 1'b0;
    feedback_arm_in_i = 1'b1;
    fork
      drive_loop();
    join_none
    repeat (4) @(negedge mclk_i);
    check("low power", 32'(low_power_o), 32'h1);
    arst_n_i = 1'b1;
    // Never armed: every code must be dropped
    repeat (100) @(negedge mclk_i);
    check("valid early", 32'(data_valid_o), 32'h0);
    repeat (2100) @(negedge mclk_i);
    check("valid late", 32'(data_valid_o), 32'h1);
    arst_n_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    check("sync in reset", 32'(frame_sync_out_o), 32'h0);
    arst_n_i = 1'b1;
    // Arm during settling so streaming starts as soon as valid
    repeat (10) @(negedge mclk_i);
    feedback_arm_in_i = 1'b0;
    armed_exp = 1'b1;
    repeat (2400) @(negedge mclk_i);
    feedback_arm_in_i = 1'b1;
    repeat (40) @(negedge mclk_i);
    check("backlog", 32'(exp_q.size() <= 2), 32'h1);
    check("words seen", 32'(n_words > 50), 32'h1);
    report_and_stop;
  end
  // Run needs about 4700 cycles
  initial begin
    repeat (6000) @(posedge mclk_i);
    errors++;
    report_and_stop;
  end
endmodule : pfadc_port_tb
